// *** pgts_pkg.sv ***
/*
 Package for the pin group timing source select block: configuration
 register map, field positions, reset values, loopback codes and valid
 clock pin masks. Assumes a 32-bit AHB-Lite register bus.
*/
package pgts_pkg;
    localparam logic [7:0] cfg_off = 8'h00;
    localparam logic [7:0] valid_off = 8'h04;
    localparam logic [7:0] clk_off = 8'h08;
    localparam int tx_line_timing_sel_bit = 0;
    localparam int tx_framer_timing_sel_bit = 1;
    localparam int rx_framer_timing_sel_bit = 2;
    localparam int loop_timed_bit = 3;
    localparam int lbm_lsb = 4;
    localparam int line_unit_enable_bit = 7;
    localparam int rate_adapter_clock_sel_bit = 8;
    localparam logic [8:0] cfg_reset = 9'h000;
    localparam logic [2:0] lbm_none = 3'h0;
    localparam logic [2:0] lbm_alb = 3'h1;
    localparam logic [2:0] lbm_llb = 3'h2;
    localparam logic [2:0] lbm_plb = 3'h3;
    localparam logic [2:0] lbm_dlb = 3'h4;
    localparam logic [2:0] lbm_lldl = 3'h6;
    // Valid pin mask bits: tx_line_clk_out, tx_clk_out, rx_clk_out, rx_line_clk_in, tx_clk_in.
    localparam logic [4:0] pin_tx_line_clk_out = 5'h01;
    localparam logic [4:0] pin_tx_clk_out = 5'h02;
    localparam logic [4:0] pin_rx_clk_out = 5'h04;
    localparam logic [4:0] pin_rx_line_clk_in = 5'h08;
    localparam logic [4:0] pin_tx_clk_in = 5'h10;
    localparam logic [4:0] pin_none = 5'h00;
    localparam int mask_w = 5;
    localparam logic [1:0] htrans_nonseq = 2'h2;
endpackage

// *** pgts_sel_if.sv ***
/*
 Interface carrying the static timing configuration from the register
 domain to the link-side pin flops. Assumes the fields are quasi static.
*/
`timescale 1ns/1ns
interface pgts_sel_if;
    logic [8:0] cfg;
    modport src (output cfg);
    modport dst (input cfg);
endinterface

// *** pgts_sync.sv ***
/*
 Three stage synchroniser for a bus of quasi static levels. Assumes the
 source changes rarely; a bit is taken once stages two and three agree.
*/
`timescale 1ns/1ns
module pgts_sync #(
    parameter int w = 9
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [w-1:0] d,
    output logic [w-1:0] q
);
    logic [w-1:0] s1;
    logic [w-1:0] s2;
    logic [w-1:0] s3;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
        end
    end
    genvar i;
    generate
        for (i = 0; i < w; i++) begin : g_bit
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    q[i] <= 1'b0;
                end else if (s2[i] == s3[i]) begin
                    q[i] <= s3[i];
                end
            end
        end
    endgenerate
endmodule

// *** pgts_pins.sv ***
/*
 Link-side boundary flops for the transmit line, transmit framer and
 receive groups, all clocked by the link clock. Assumes the chosen pin
 clock reaches this module before the internal clock tree.
*/
`timescale 1ns/1ns
module pgts_pins (
    input wire logic link_clk,
    input wire logic link_rst_n,
    pgts_sel_if.dst sel,
    input wire logic tx_serial_data,
    input wire logic tx_frame_start_in,
    input wire logic rx_line_pos_data,
    input wire logic rx_line_neg_violation,
    input wire logic [3:0] core_out,
    output logic [3:0] pin_out,
    output logic [3:0] pin_in
);
    // Every group passes exactly one flop on the selected pin clock. RULE13
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            pin_out <= 4'h0;
        end else begin
            pin_out <= core_out; // RULE1
        end
    end
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            pin_in <= 4'h0;
        end else if (sel.cfg[pgts_pkg::line_unit_enable_bit]) begin
            // Line unit owns the receive line, so those pins are ignored.
            pin_in <= {2'h0, tx_frame_start_in, tx_serial_data}; // RULE9
        end else begin
            pin_in <= {rx_line_neg_violation, rx_line_pos_data,
                       tx_frame_start_in, tx_serial_data};
        end
    end
endmodule

// *** pgts_top.sv ***
/*
 Pin group timing source select: AHB-Lite configuration, valid clock pin
 masks per pin group, and the link side boundary flops. Assumes one
 master, word transfers, and a link clock from the chosen pin.
*/
// Overview of operation
// RULE1: Transmit line pins launch from the transmit line clock source.
// RULE2: Timing select zero makes the transmit line clock output valid.
// RULE3: Transmit line select: zero output clock timing, one input timing.
// RULE4: Outside logic uses the selected pin kind; internal sources none.
// RULE5: Input timing, normal, no line loops: input clock iff adapter one.
// RULE6: Input timing with line loops: receive line clock if unit off.
// RULE7: Framer transmit pins follow transmit clock output source.
// RULE8: Payload, diagnostic, analog loops make three output clocks valid; framer code takes analog loop only with the line unit off.
// RULE9: Receive line pins use receive line clock; none if unit on.
// RULE10: Receive framer pins follow receive clock output source.
// RULE11: Receive framer input timing depends on loop, adapter, unit.
// RULE12: Timing selects are static config choosing boundary flop clocks.
// RULE13: Each pin passes one flop on the chosen pin clock.
// RULE14: Loopback typically moves framer and line clocks to another source.
`timescale 1ns/1ns
module pgts_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic link_clk,
    input wire logic link_rst_n,
    input wire logic tx_serial_data,
    input wire logic tx_frame_start_in,
    input wire logic rx_line_pos_data,
    input wire logic rx_line_neg_violation,
    input wire logic [3:0] core_out,
    output logic tx_line_pos_data,
    output logic tx_line_neg,
    output logic tx_frame_start_out,
    output logic rx_serial_data,
    output logic [3:0] pin_in,
    output logic [4:0] tx_line_valid,
    output logic [4:0] tx_framer_valid,
    output logic [4:0] rx_line_valid,
    output logic [4:0] rx_framer_valid
);
    logic [8:0] cfg;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr_q;
    logic [4:0] next_tl;
    logic [4:0] next_tf;
    logic [4:0] next_rl;
    logic [4:0] next_rf;
    logic [1:0] tl_src;
    logic [1:0] tf_src;
    logic [1:0] rf_src;
    logic [3:0] pin_out;
    logic tx_line_timing_sel;
    logic tx_framer_timing_sel;
    logic rx_framer_timing_sel;
    logic loop_timed;
    logic [2:0] lbm;
    logic line_unit_enable;
    logic rate_adapter_clock_sel;
    logic line_lp;
    logic dlb_any;
    pgts_sel_if sel_a ();

    assign tx_line_timing_sel = cfg[pgts_pkg::tx_line_timing_sel_bit];
    assign tx_framer_timing_sel = cfg[pgts_pkg::tx_framer_timing_sel_bit];
    assign rx_framer_timing_sel = cfg[pgts_pkg::rx_framer_timing_sel_bit];
    assign loop_timed = cfg[pgts_pkg::loop_timed_bit];
    assign lbm = cfg[pgts_pkg::lbm_lsb +: 3];
    assign line_unit_enable = cfg[pgts_pkg::line_unit_enable_bit];
    assign rate_adapter_clock_sel = cfg[pgts_pkg::rate_adapter_clock_sel_bit];
    assign line_lp = (lbm == pgts_pkg::lbm_llb) ||
        (lbm == pgts_pkg::lbm_plb) || (lbm == pgts_pkg::lbm_lldl);
    assign dlb_any = (lbm == pgts_pkg::lbm_dlb) ||
        (lbm == pgts_pkg::lbm_lldl);

    // Bus slave: zero wait states, always OKAY.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q <= 8'h00;
        end else if (hready) begin
            wr_pend <= hsel && htrans == pgts_pkg::htrans_nonseq && hwrite;
            rd_pend <= hsel && htrans == pgts_pkg::htrans_nonseq && !hwrite;
            addr_q <= haddr[7:0];
        end
    end

    // Selects are static config written only by software. RULE12
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg <= pgts_pkg::cfg_reset;
        end else if (wr_pend && addr_q == pgts_pkg::cfg_off) begin
            cfg <= hwdata[8:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (hready && hsel && htrans == pgts_pkg::htrans_nonseq
                     && !hwrite) begin
            if (haddr[7:0] == pgts_pkg::cfg_off) begin
                hrdata <= {23'h000000, cfg};
            end else if (haddr[7:0] == pgts_pkg::valid_off) begin
                hrdata <= {12'h000, next_rf, next_rl, next_tf, next_tl};
            end else if (haddr[7:0] == pgts_pkg::clk_off) begin
                hrdata <= {26'h0000000, rf_src, tf_src, tl_src};
            end else begin
                hrdata <= 32'h00000000;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Functional clock source codes: 0 line unit, 1 rx line clk in,
    // 2 rate adapter, 3 tx clk in. Loopbacks move sources. RULE14
    always_comb begin
        if (loop_timed || line_lp) begin
            tl_src = line_unit_enable ? 2'h0 : 2'h1; // RULE1
        end else begin
            tl_src = rate_adapter_clock_sel ? 2'h3 : 2'h2;
        end
        if (loop_timed || lbm == pgts_pkg::lbm_plb) begin
            tf_src = line_unit_enable ? 2'h0 : 2'h1; // RULE7
        end else begin
            tf_src = rate_adapter_clock_sel ? 2'h3 : 2'h2;
        end
        if (loop_timed || (!lbm[2] && !(lbm == pgts_pkg::lbm_alb && !line_unit_enable))) begin
            rf_src = line_unit_enable ? 2'h0 : 2'h1; // RULE10
        end else begin
            rf_src = rate_adapter_clock_sel ? 2'h3 : 2'h2;
        end
    end

    // Transmit line group valid pins.
    always_comb begin
        if (!tx_line_timing_sel) begin
            // Output timing: line clock always valid. RULE2 RULE3
            if (loop_timed || lbm == pgts_pkg::lbm_dlb) begin
                next_tl = pgts_pkg::pin_tx_line_clk_out | pgts_pkg::pin_tx_clk_out |
                    pgts_pkg::pin_rx_clk_out;
            end else if (lbm == pgts_pkg::lbm_llb ||
                         lbm == pgts_pkg::lbm_plb) begin
                next_tl = pgts_pkg::pin_tx_line_clk_out | pgts_pkg::pin_rx_clk_out;
            end else if (lbm == pgts_pkg::lbm_lldl) begin
                next_tl = pgts_pkg::pin_tx_line_clk_out;
            end else begin
                next_tl = pgts_pkg::pin_tx_line_clk_out | pgts_pkg::pin_tx_clk_out;
            end
        end else if (loop_timed || line_lp) begin
            // Internal sources leave no input pin. RULE4 RULE6
            next_tl = line_unit_enable ? pgts_pkg::pin_none : pgts_pkg::pin_rx_line_clk_in;
        end else begin
            next_tl = rate_adapter_clock_sel ? pgts_pkg::pin_tx_clk_in : pgts_pkg::pin_none; // RULE5
        end
    end

    // Transmit framer group valid pins.
    always_comb begin
        if (!tx_framer_timing_sel) begin
            if (loop_timed || lbm == pgts_pkg::lbm_plb ||
                lbm == pgts_pkg::lbm_dlb ||
                (lbm == pgts_pkg::lbm_alb && !line_unit_enable)) begin
                next_tf = pgts_pkg::pin_tx_clk_out | pgts_pkg::pin_tx_line_clk_out |
                    pgts_pkg::pin_rx_clk_out; // RULE8
            end else if (lbm == pgts_pkg::lbm_lldl) begin
                next_tf = pgts_pkg::pin_tx_clk_out | pgts_pkg::pin_rx_clk_out;
            end else if (lbm == pgts_pkg::lbm_llb) begin
                next_tf = pgts_pkg::pin_tx_clk_out;
            end else begin
                next_tf = pgts_pkg::pin_tx_clk_out | pgts_pkg::pin_tx_line_clk_out; // RULE7
            end
        end else if (loop_timed || lbm == pgts_pkg::lbm_plb) begin
            next_tf = line_unit_enable ? pgts_pkg::pin_none : pgts_pkg::pin_rx_line_clk_in;
        end else begin
            next_tf = rate_adapter_clock_sel ? pgts_pkg::pin_tx_clk_in : pgts_pkg::pin_none;
        end
    end

    // Receive line and receive framer groups.
    always_comb begin
        next_rl = line_unit_enable ? pgts_pkg::pin_none : pgts_pkg::pin_rx_line_clk_in; // RULE9
        if (!rx_framer_timing_sel) begin
            if (loop_timed || lbm == pgts_pkg::lbm_plb ||
                lbm == pgts_pkg::lbm_dlb ||
                (lbm == pgts_pkg::lbm_alb && !line_unit_enable)) begin
                next_rf = pgts_pkg::pin_rx_clk_out | pgts_pkg::pin_tx_line_clk_out |
                    pgts_pkg::pin_tx_clk_out; // RULE10
            end else if (lbm == pgts_pkg::lbm_lldl) begin
                next_rf = pgts_pkg::pin_rx_clk_out | pgts_pkg::pin_tx_clk_out;
            end else if (lbm == pgts_pkg::lbm_llb) begin
                next_rf = pgts_pkg::pin_rx_clk_out | pgts_pkg::pin_tx_line_clk_out;
            end else begin
                next_rf = pgts_pkg::pin_rx_clk_out;
            end
        end else if (!loop_timed && dlb_any) begin
            next_rf = rate_adapter_clock_sel ? pgts_pkg::pin_tx_clk_in : pgts_pkg::pin_none; // RULE11
        end else begin
            next_rf = line_unit_enable ? pgts_pkg::pin_none : pgts_pkg::pin_rx_line_clk_in; // RULE11
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_line_valid <= pgts_pkg::pin_none;
            tx_framer_valid <= pgts_pkg::pin_none;
            rx_line_valid <= pgts_pkg::pin_none;
            rx_framer_valid <= pgts_pkg::pin_none;
        end else begin
            tx_line_valid <= next_tl;
            tx_framer_valid <= next_tf;
            rx_line_valid <= next_rl;
            rx_framer_valid <= next_rf;
        end
    end

    // Config crosses to the link domain through three sync flops and a filtered output flop.
    pgts_sync #(.w(9)) u_sync (
        .clk(link_clk),
        .rst_n(link_rst_n),
        .d(cfg),
        .q(sel_a.cfg)
    );

    pgts_pins u_pins (
        .link_clk(link_clk),
        .link_rst_n(link_rst_n),
        .sel(sel_a.dst),
        .tx_serial_data(tx_serial_data),
        .tx_frame_start_in(tx_frame_start_in),
        .rx_line_pos_data(rx_line_pos_data),
        .rx_line_neg_violation(rx_line_neg_violation),
        .core_out(core_out),
        .pin_out(pin_out),
        .pin_in(pin_in)
    );
    assign tx_line_pos_data = pin_out[0];
    assign tx_line_neg = pin_out[1];
    assign tx_frame_start_out = pin_out[2];
    assign rx_serial_data = pin_out[3];

    chk_tl_out_valid: assert property (@(posedge hclk) disable iff (!hresetn)
        !tx_line_timing_sel |=> tx_line_valid[0]) else $error("line clock not valid"); // RULE2
    chk_tf_out_valid: assert property (@(posedge hclk) disable iff (!hresetn)
        !tx_framer_timing_sel |=> tx_framer_valid[1]) else $error("tx_clk_out not valid"); // RULE7
    chk_rf_out_valid: assert property (@(posedge hclk) disable iff (!hresetn)
        !rx_framer_timing_sel |=> rx_framer_valid[2]) else $error("rx_clk_out not valid"); // RULE10
    chk_rl_unit_on: assert property (@(posedge hclk) disable iff (!hresetn)
        line_unit_enable |=> rx_line_valid == 5'h00) else $error("rx line valid"); // RULE9
    chk_tl_tx_clk_in: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_line_timing_sel && !loop_timed && !line_lp |=> tx_line_valid[4] == $past(rate_adapter_clock_sel))
        else $error("tx_clk_in select wrong"); // RULE5
    chk_tl_rx_line_clk_in: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_line_timing_sel && line_lp && !loop_timed |=> tx_line_valid[3] == !$past(line_unit_enable))
        else $error("rx_line_clk_in select wrong"); // RULE6
    chk_tl_input_kind: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_line_timing_sel |=> tx_line_valid[2:0] == 3'h0) else $error("output pin"); // RULE3
    chk_tf_three: assert property (@(posedge hclk) disable iff (!hresetn)
        !tx_framer_timing_sel && !loop_timed && lbm == pgts_pkg::lbm_dlb |=> tx_framer_valid == 5'h07)
        else $error("framer loop mask"); // RULE8
    chk_rf_dlb_in: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_framer_timing_sel && !loop_timed && dlb_any && !rate_adapter_clock_sel |=> rx_framer_valid == 5'h00)
        else $error("rx framer mask"); // RULE11
    cov_loop_timed: cover property (@(posedge hclk) loop_timed && tx_line_timing_sel);
    cov_plb: cover property (@(posedge hclk) lbm == pgts_pkg::lbm_plb);
    cov_dlb_in: cover property (@(posedge hclk) rx_framer_timing_sel && dlb_any && rate_adapter_clock_sel);
endmodule

// *** pgts_far_end.sv ***
/*
 Far end model: outside framing logic that drives the transmit framer and
 receive line input pins. Assumes the link clock stands for the clock pin
 that the timing selects name as valid.
*/
`timescale 1ns/1ns
module pgts_far_end (
    input wire logic link_clk,
    input wire logic link_rst_n,
    output logic tx_serial_data,
    output logic tx_frame_start_in,
    output logic rx_line_pos_data,
    output logic rx_line_neg_violation
);
    logic [4:0] lfsr;

    // Each line is one tap of a five bit LFSR, so a stale sample soon mismatches.
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            lfsr <= 5'h15;
        end else begin
            lfsr <= {lfsr[3:0], lfsr[4] ^ lfsr[2]};
        end
    end

    assign tx_serial_data = lfsr[0];
    assign tx_frame_start_in = lfsr[1];
    // Receive line data moves on the link clock, like every other line here.
    assign rx_line_pos_data = lfsr[2];
    assign rx_line_neg_violation = lfsr[3];
endmodule

// *** tb.sv ***
/*
 Testbench for the pin group timing source select block. Assumes one
 AHB-Lite master, zero wait states and a free running link clock.
*/
`timescale 1ns/1ns
module tb;
    logic hclk = 1'b0;
    logic hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, ed;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic link_clk, link_rst_n;
    logic tx_serial_data, tx_frame_start_in;
    logic rx_line_pos_data, rx_line_neg_violation;
    logic tx_line_pos_data, tx_line_neg, tx_frame_start_out, rx_serial_data;
    logic [3:0] core_out, pin_in;
    logic [4:0] tx_line_valid, tx_framer_valid, rx_line_valid;
    logic [4:0] rx_framer_valid;
    logic [19:0] pins_v, em;
    logic [8:0] cfg_m, c;
    logic [7:0] ln;
    logic lk_on, dp_rd;
    logic [31:0] eq_d[$];
    logic [19:0] eq_m[$];
    logic [7:0] lq[$];
    int error_cnt = 0;
    int n_compared = 0;

    assign hready = hreadyout;
    assign pins_v = {rx_framer_valid, rx_line_valid, tx_framer_valid,
                     tx_line_valid};

    pgts_top uut (.*);
    pgts_far_end far (.*);

    always #50 hclk = ~hclk;

    initial begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = ~link_clk;
    end

    function automatic logic [19:0] ref_mask(input logic [8:0] c);
        logic [4:0] k, o, r, l, x, t;
        logic [2:0] m;
        k = pgts_pkg::pin_tx_line_clk_out;
        o = pgts_pkg::pin_tx_clk_out;
        r = pgts_pkg::pin_rx_clk_out;
        l = c[7] ? pgts_pkg::pin_none : pgts_pkg::pin_rx_line_clk_in;
        x = c[8] ? pgts_pkg::pin_tx_clk_in : pgts_pkg::pin_none;
        m = c[6:4];
        if (c[3]) t = c[0] ? l : k | o | r;
        else if (c[0]) t = (m == 3'h2 || m == 3'h3 || m == 3'h6) ? l : x;
        else if (m == 3'h4) t = k | o | r;
        else if (m == 3'h2 || m == 3'h3) t = k | r;
        else if (m == 3'h6) t = k;
        else t = k | o;
        ref_mask[4:0] = t;
        if (c[3]) t = c[1] ? l : k | o | r;
        else if (c[1]) t = (m == 3'h3) ? l : x;
        else if (m == 3'h3 || m == 3'h4 || (m == 3'h1 && !c[7])) t = k | o | r;
        else if (m == 3'h6) t = o | r;
        else if (m == 3'h2) t = o;
        else t = o | k;
        ref_mask[9:5] = t;
        ref_mask[14:10] = l;
        if (c[3]) t = c[2] ? l : k | o | r;
        else if (c[2]) t = (m == 3'h4 || m == 3'h6) ? x : l;
        else if (m == 3'h3 || m == 3'h4 || (m == 3'h1 && !c[7])) t = k | o | r;
        else if (m == 3'h6) t = r | o;
        else if (m == 3'h2) t = r | k;
        else t = r;
        ref_mask[19:15] = t;
    endfunction

    function automatic logic [5:0] ref_src(input logic [8:0] c);
        logic [1:0] s, x;
        logic [2:0] m;
        m = c[6:4];
        s = c[7] ? 2'h0 : 2'h1;
        x = c[8] ? 2'h3 : 2'h2;
        if (c[3]) ref_src = {s, s, s};
        else begin
            ref_src[1:0] = (m == 3'h2 || m == 3'h3 || m == 3'h6) ? s : x;
            ref_src[3:2] = (m == 3'h3) ? s : x;
            ref_src[5:4] = (m[2] || (m == 3'h1 && !c[7])) ? x : s;
        end
    endfunction

    task automatic miss(input string n, input logic [31:0] e,
                        input logic [31:0] g);
        error_cnt++;
        $display("MISMATCH %s expected %h seen %h", n, e, g);
    endtask

    task automatic test_done;
        if (error_cnt == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Reads note the expected word; the monitor compares at completion.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        if (w && a == pgts_pkg::cfg_off) cfg_m = d[8:0];
        if (!w) begin
            eq_d.push_back(d);
            eq_m.push_back(ref_mask(cfg_m));
        end
        hsel <= 1'b1;
        htrans <= pgts_pkg::htrans_nonseq;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= w ? d : 32'h0;
        do @(posedge hclk); while (hready !== 1'b1);
    endtask

    always @(posedge hclk) begin
        if (hready === 1'b1) begin
            if (dp_rd) begin
                ed = eq_d.pop_front();
                em = eq_m.pop_front();
                n_compared++;
                if (hrdata !== ed)
                    miss("hrdata", ed, hrdata);
                if (pins_v !== em)
                    miss("valid_pins", 32'(em), 32'(pins_v));
                if (hresp !== 1'b0)
                    miss("hresp", 32'h0, 32'(hresp));
            end
            dp_rd = hsel && htrans == pgts_pkg::htrans_nonseq && !hwrite;
        end
    end

    always @(posedge link_clk) begin
        core_out <= 4'($urandom());
        #1;
        if (lk_on) lq.push_back({cfg_m[7] ? 2'h0 : {rx_line_neg_violation,
            rx_line_pos_data}, tx_frame_start_in, tx_serial_data, core_out});
    end

    // Pin flops add one link cycle, so a note is checked one edge later.
    always @(posedge link_clk) begin
        #2;
        if (lk_on && lq.size() > 1) begin
            ln = lq.pop_front();
            n_compared++;
            if ({rx_serial_data, tx_frame_start_out, tx_line_neg,
                 tx_line_pos_data} !== ln[3:0])
                miss("pin_out", 32'(ln[3:0]), 32'({rx_serial_data,
                     tx_frame_start_out, tx_line_neg, tx_line_pos_data}));
            if (pin_in !== ln[7:4])
                miss("pin_in", 32'(ln[7:4]), 32'(pin_in));
        end
    end

    initial begin
        #3000000;
        error_cnt++;
        test_done();
    end

    initial begin
        void'($urandom(32'hD8A6));
        hresetn = 1'b0;
        link_rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        core_out = 4'h0;
        lk_on = 1'b0;
        dp_rd = 1'b0;
        cfg_m = pgts_pkg::cfg_reset;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        link_rst_n <= 1'b1;
        @(posedge hclk);
        xfer(1'b0, pgts_pkg::cfg_off, 32'h0);
        xfer(1'b0, pgts_pkg::valid_off, {12'h0, ref_mask(cfg_m)});
        xfer(1'b1, pgts_pkg::valid_off, 32'hFFFF_FFFF);
        xfer(1'b1, 8'h0C, 32'hFFFF_FFFF);
        xfer(1'b0, 8'h0C, 32'h0);
        xfer(1'b0, pgts_pkg::cfg_off, 32'h0);
        for (int n = 0; n < 512; n++) begin
            c = n[8:0];
            if (c[6:4] != 3'h5 && c[6:4] != 3'h7) begin
                xfer(1'b1, 8'h00, ($urandom() & 32'hFFFF_FE00) | 32'(n));
                xfer(1'b0, pgts_pkg::valid_off, {12'h0, ref_mask(c)});
                xfer(1'b0, pgts_pkg::clk_off, {26'h0, ref_src(c)});
                xfer(1'b0, pgts_pkg::cfg_off, {23'h0, c});
            end
        end
        for (int u = 0; u < 2; u++) begin
            xfer(1'b1, pgts_pkg::cfg_off, 32'(u) << pgts_pkg::line_unit_enable_bit);
            repeat (10) @(posedge link_clk);
            #5 lk_on = 1'b1;
            repeat (40) @(posedge link_clk);
            #5 lk_on = 1'b0;
            lq.delete();
        end
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        cfg_m = pgts_pkg::cfg_reset;
        @(posedge hclk);
        xfer(1'b0, pgts_pkg::cfg_off, 32'h0);
        xfer(1'b0, pgts_pkg::valid_off, {12'h0, ref_mask(cfg_m)});
        repeat (2) @(posedge hclk);
        test_done();
    end
endmodule
